// ---- design/sfr_pkg.sv ----
package sfr_pkg;
	// ----------------------------------------------------------------
	// bus and map
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W_DEF = 12;
	localparam int unsigned REG_W = 8;
	localparam int unsigned IDX_W = 3;
	localparam int unsigned BYTE_SHIFT = 2;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 3'h0;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN_UP = 3'h1;
	localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS = 3'h2;
	localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS_UP = 3'h3;
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 3'h4;
	localparam logic [IDX_W-1:0] IDX_EVT_MASK = 3'h5;
	// ----------------------------------------------------------------
	// enable register fields
	// ----------------------------------------------------------------
	localparam int unsigned EN_WATCHDOG = 0;
	localparam int unsigned EN_OSC_FAULT = 1;
	localparam int unsigned EN_NONMASK = 4;
	localparam int unsigned EN_FLASH_VIOL = 5;
	localparam logic [REG_W-1:0] EN_IMPL = 8'h33;
	localparam logic [REG_W-1:0] EN_RESET = 8'h00;
	// ----------------------------------------------------------------
	// flag register fields
	// ----------------------------------------------------------------
	localparam int unsigned FL_WATCHDOG = 0;
	localparam int unsigned FL_OSC_FAULT = 1;
	localparam int unsigned FL_POWER_ON = 2;
	localparam int unsigned FL_EXT_RESET = 3;
	localparam int unsigned FL_NONMASK = 4;
	localparam logic [REG_W-1:0] FL_IMPL = 8'h1f;
	localparam logic [REG_W-1:0] FL_RESET = 8'h06;
	// ----------------------------------------------------------------
	// event status / mask fields
	// ----------------------------------------------------------------
	localparam int unsigned EVT_W = 5;
	localparam int unsigned EV_WATCHDOG = 0;
	localparam int unsigned EV_OSC_FAULT = 1;
	localparam int unsigned EV_NONMASK = 2;
	localparam int unsigned EV_EXT_RESET = 3;
	localparam int unsigned EV_FLASH_VIOL = 4;
	localparam logic [EVT_W-1:0] EVT_RESET = 5'h00;
endpackage : sfr_pkg

// ---- design/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int unsigned WIDTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// asynchronous inputs and their synchronised copies
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	// first stage feeds only the second stage
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule : pin_sync
`default_nettype wire

// ---- design/event_irq.sv ----
`timescale 1ns/100ps
`default_nettype none
module event_irq #(
	parameter int unsigned WIDTH = 5
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// one-cycle event pulses
	input wire logic [WIDTH-1:0] evt,
	// software access
	input wire logic wr_status,
	input wire logic wr_mask,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] mask,
	// interrupt line
	output logic irq
);
	typedef struct packed {
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] mask;
		logic irq;
	} evt_t;

	evt_t st_r;
	evt_t st_nxt;
	logic [WIDTH-1:0] clr;

	// write-one-to-clear; a new event in the clearing cycle survives
	always_comb begin
		st_nxt = st_r;
		clr = wr_status ? wdata : '0;
		st_nxt.status = (st_r.status & ~clr) | evt;
		if (wr_mask) begin
			st_nxt.mask = wdata;
		end
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign status = st_r.status;
	assign mask = st_r.mask;
	assign irq = st_r.irq;
endmodule : event_irq
`default_nettype wire

// ---- design/sfr_bank.sv ----
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sfr_bank #(
	parameter int unsigned ADDR_W = sfr_pkg::ADDR_W_DEF
) (
	// clock and power-on reset
	input wire logic clk,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [sfr_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [sfr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// system reset control, same clock
	input wire logic power_up_clear,
	// watchdog, same clock
	input wire logic watchdog_overflow,
	input wire logic watchdog_interval_mode,
	// flash controller, same clock
	input wire logic flash_violation,
	// reset/nmi pin function select, same clock
	input wire logic nmi_mode,
	input wire logic nmi_edge_falling,
	// asynchronous sources
	input wire logic rst_nmi_pin_n,
	input wire logic osc_fault,
	// register contents for the rest of the system
	output logic [sfr_pkg::REG_W-1:0] irq_enables,
	output logic [sfr_pkg::REG_W-1:0] irq_flags,
	// interrupt requests
	output logic watchdog_irq_req,
	output logic nonmask_irq_req,
	output logic irq
);
	import sfr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [REG_W-1:0] en;
		logic [REG_W-1:0] fl;
		logic [DATA_W-1:0] rdata;
		logic slverr;
		logic pin_d;
		logic osc_d;
		logic flash_d;
		logic wd_req;
		logic nm_req;
	} bank_t;

	bank_t st_r;
	bank_t st_nxt;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sync_q;
	logic pin_s;
	logic osc_s;

	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({~rst_nmi_pin_n, osc_fault}),
		.q(sync_q)
	);

	// pin travels inverted so a cleared synchroniser equals its idle high level;
	// otherwise every reset release would fake a pin reset condition
	assign pin_s = ~sync_q[1];
	assign osc_s = sync_q[0];

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic aligned;
	logic in_map;
	logic [IDX_W-1:0] idx;
	logic wr_en;
	logic wr_irq_en;
	logic wr_irq_flags;
	logic wr_evt_status;
	logic wr_evt_mask;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign idx = paddr[BYTE_SHIFT +: IDX_W];
	assign aligned = (paddr[BYTE_SHIFT-1:0] == WORD_ALIGN);
	// upper address bits must be clear; the map is a handful of words
	assign in_map = aligned && (paddr[ADDR_W-1:BYTE_SHIFT+IDX_W] == '0)
		&& (idx <= IDX_EVT_MASK);
	// registers are byte wide, so only lane 0 carries a write
	assign wr_en = access & pwrite & pstrb[0] & in_map;
	assign wr_irq_en = wr_en && (idx == IDX_IRQ_EN);
	assign wr_irq_flags = wr_en && (idx == IDX_IRQ_FLAGS);
	assign wr_evt_status = wr_en && (idx == IDX_EVT_STATUS);
	assign wr_evt_mask = wr_en && (idx == IDX_EVT_MASK);

	// no wait state: pready in the first access cycle, read data still straight from a flop
	assign pready = access;
	assign prdata = st_r.rdata;
	assign pslverr = st_r.slverr & access;

	// ----------------------------------------------------------------
	// pin and source events
	// ----------------------------------------------------------------
	logic nmi_edge;
	logic rst_cond;
	logic rst_edge;
	logic osc_rise;
	logic flash_rise;
	logic [EVT_W-1:0] evt_vec;
	logic [EVT_W-1:0] evt_status;
	logic [EVT_W-1:0] evt_mask;

	// in nmi mode the selected edge of the pin is the event
	assign nmi_edge = nmi_mode & (nmi_edge_falling ? (st_r.pin_d & ~pin_s)
		: (~st_r.pin_d & pin_s));
	// in reset mode a low pin is a reset condition
	assign rst_cond = ~nmi_mode & ~pin_s;
	assign rst_edge = ~nmi_mode & st_r.pin_d & ~pin_s;
	assign osc_rise = osc_s & ~st_r.osc_d;
	assign flash_rise = flash_violation & ~st_r.flash_d;

	always_comb begin
		evt_vec = EVT_RESET;
		evt_vec[EV_WATCHDOG] = watchdog_overflow;
		evt_vec[EV_OSC_FAULT] = osc_rise;
		evt_vec[EV_NONMASK] = nmi_edge;
		evt_vec[EV_EXT_RESET] = rst_edge;
		evt_vec[EV_FLASH_VIOL] = flash_rise;
	end

	event_irq #(
		.WIDTH(EVT_W)
	) u_event_irq (
		.clk(clk),
		.arst_n(arst_n),
		.evt(evt_vec),
		.wr_status(wr_evt_status),
		.wr_mask(wr_evt_mask),
		.wdata(pwdata[EVT_W-1:0]),
		.status(evt_status),
		.mask(evt_mask),
		.irq(irq)
	);

	// ----------------------------------------------------------------
	// read mux, captured in the setup cycle
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_word;
	logic rd_err;

	always_comb begin
		rd_word = '0;
		rd_err = 1'b0;
		if (!in_map) begin
			rd_err = 1'b1;
		end else begin
			case (idx)
				IDX_IRQ_EN: begin
					rd_word = DATA_W'(st_r.en & EN_IMPL);
				end
				IDX_IRQ_FLAGS: begin
					rd_word = DATA_W'(st_r.fl & FL_IMPL);
				end
				IDX_IRQ_EN_UP, IDX_IRQ_FLAGS_UP: begin
					rd_word = '0;
				end
				IDX_EVT_STATUS: begin
					rd_word = DATA_W'(evt_status);
				end
				IDX_EVT_MASK: begin
					rd_word = DATA_W'(evt_mask);
				end
				default: begin
					rd_err = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pin_d = pin_s;
		st_nxt.osc_d = osc_s;
		st_nxt.flash_d = flash_violation;
		if (setup) begin
			st_nxt.rdata = rd_word;
			st_nxt.slverr = rd_err | (pwrite & ~in_map);
		end
		// software writes land first; the upper registers have no storage
		if (wr_irq_en) begin
			st_nxt.en = pwdata[REG_W-1:0] & EN_IMPL;
		end
		if (wr_irq_flags) begin
			st_nxt.fl = pwdata[REG_W-1:0] & FL_IMPL;
		end
		// power-up clear leaves the power-on-reset-only flags alone
		if (power_up_clear) begin
			st_nxt.en = EN_RESET;
			st_nxt.fl[FL_OSC_FAULT] = 1'b1;
			st_nxt.fl[FL_NONMASK] = 1'b0;
		end
		// hardware sets come last so a set outlives a clear
		if (watchdog_overflow) begin
			st_nxt.fl[FL_WATCHDOG] = 1'b1;
		end
		if (osc_s) begin
			st_nxt.fl[FL_OSC_FAULT] = 1'b1;
		end
		if (rst_cond) begin
			st_nxt.fl[FL_EXT_RESET] = 1'b1;
		end
		if (nmi_edge) begin
			st_nxt.fl[FL_NONMASK] = 1'b1;
		end
		// watchdog enable matters only as an interval timer
		st_nxt.wd_req = st_nxt.fl[FL_WATCHDOG] & st_nxt.en[EN_WATCHDOG]
			& watchdog_interval_mode;
		// no general enable reaches these requests
		st_nxt.nm_req = (st_nxt.fl[FL_OSC_FAULT] & st_nxt.en[EN_OSC_FAULT])
			| (st_nxt.fl[FL_NONMASK] & st_nxt.en[EN_NONMASK])
			| (flash_violation & st_nxt.en[EN_FLASH_VIOL]);
	end

	// ----------------------------------------------------------------
	// registers; the asynchronous reset is the power-on reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.en <= EN_RESET;
			st_r.fl <= FL_RESET;
			st_r.rdata <= '0;
			st_r.slverr <= 1'b0;
			st_r.pin_d <= 1'b1;
			st_r.osc_d <= 1'b0;
			st_r.flash_d <= 1'b0;
			st_r.wd_req <= 1'b0;
			st_r.nm_req <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign irq_enables = st_r.en;
	assign irq_flags = st_r.fl;
	assign watchdog_irq_req = st_r.wd_req;
	assign nonmask_irq_req = st_r.nm_req;
endmodule : sfr_bank
`default_nettype wire

// ---- test/sfr_bank_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfr_bank_assertions #(
	parameter int unsigned ADDR_W = 12
) (
	// clock, reset and bus
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// system side
	input wire logic power_up_clear,
	input wire logic watchdog_overflow,
	input wire logic watchdog_interval_mode,
	input wire logic flash_violation,
	input wire logic nmi_mode,
	input wire logic osc_fault,
	input wire logic [sfr_pkg::REG_W-1:0] irq_enables,
	input wire logic [sfr_pkg::REG_W-1:0] irq_flags,
	input wire logic watchdog_irq_req,
	input wire logic nonmask_irq_req
);
	import sfr_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_PREADY: assert property (psel && penable |-> pready)
		else $error("no ready in access cycle");
	AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	AST_NO_STORAGE: assert property ((irq_enables & 8'hcc) == 8'h00 && irq_flags[7:5] == 3'h0)
		else $error("unassigned bit holds a one");
	AST_PUC_EN: assert property (power_up_clear |=> irq_enables == 8'h00)
		else $error("enables survive power-up clear");
	AST_PUC_OSC: assert property (power_up_clear |=> irq_flags[1])
		else $error("osc flag not set by power-up clear");
	AST_PUC_NMI: assert property (power_up_clear && !nmi_mode |=> !irq_flags[4])
		else $error("nonmask flag survives power-up clear");
	AST_WD_SET: assert property (watchdog_overflow |=> irq_flags[0])
		else $error("watchdog flag not set");
	AST_WD_REQ: assert property (watchdog_irq_req == (irq_flags[0] && irq_enables[0]
		&& $past(watchdog_interval_mode)))
		else $error("watchdog request wrong");
	AST_FLASH_REQ: assert property ($past(flash_violation) && irq_enables[5] |-> nonmask_irq_req)
		else $error("flash violation request missing");
	AST_OSC_SET: assert property (osc_fault [*3] |=> irq_flags[1])
		else $error("osc flag not set on fault");
endmodule : sfr_bank_assertions
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	import sfr_pkg::*;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, power_up_clear;
	logic watchdog_overflow, watchdog_interval_mode, flash_violation, nmi_mode;
	logic nmi_edge_falling, rst_nmi_pin_n, osc_fault, watchdog_irq_req, nonmask_irq_req, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] irq_enables, irq_flags;
	int n_errors, compares;
	sfr_bank #(.ADDR_W(12)) sfr_bank_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .power_up_clear(power_up_clear),
		.watchdog_overflow(watchdog_overflow), .watchdog_interval_mode(watchdog_interval_mode),
		.flash_violation(flash_violation), .nmi_mode(nmi_mode),
		.nmi_edge_falling(nmi_edge_falling), .rst_nmi_pin_n(rst_nmi_pin_n),
		.osc_fault(osc_fault), .irq_enables(irq_enables), .irq_flags(irq_flags),
		.watchdog_irq_req(watchdog_irq_req), .nonmask_irq_req(nonmask_irq_req), .irq(irq));
	always #2 clk = ~clk;
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one apb transfer; held until pready is seen at a rising edge
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ex,
		input logic ee);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
		if (!w) chk("prdata", prdata, ex);
		chk("pslverr", 32'(pslverr), 32'(ee));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : acc
	task wd_pulse;
		watchdog_overflow <= 1'b1;
		@(posedge clk);
		watchdog_overflow <= 1'b0;
		@(posedge clk);
	endtask : wd_pulse
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, arst_n, psel, penable, pwrite, power_up_clear, watchdog_overflow} = '0;
		{watchdog_interval_mode, flash_violation, nmi_mode, nmi_edge_falling, osc_fault} = '0;
		rst_nmi_pin_n = 1'b1;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		cyc(16);
		arst_n <= 1'b1;
		@(posedge clk);
		chk("en_rst", 32'(irq_enables), 32'h00);
		acc(0, 12'h008, 0, 32'h06, 0);
		acc(1, 12'h000, 32'hff, 0, 0);
		acc(0, 12'h000, 0, 32'h33, 0);
		pstrb <= 4'he;
		acc(1, 12'h000, 32'h00, 0, 0);
		pstrb <= 4'hf;
		acc(0, 12'h000, 0, 32'h33, 0);
		acc(1, 12'h004, 32'hff, 0, 0);
		acc(0, 12'h004, 0, 0, 0);
		acc(1, 12'h00c, 32'hff, 0, 0);
		acc(0, 12'h00c, 0, 0, 0);
		acc(0, 12'h002, 0, 0, 1);
		acc(0, 12'h018, 0, 0, 1);
		acc(1, 12'h008, 32'hff, 0, 0);
		acc(0, 12'h008, 0, 32'h1f, 0);
		acc(1, 12'h008, 0, 0, 0);
		acc(0, 12'h008, 0, 0, 0);
		wd_pulse();
		chk("wd_flag", 32'(irq_flags), 32'h01);
		chk("wd_req_off", 32'(watchdog_irq_req), 0);
		watchdog_interval_mode <= 1'b1;
		cyc(2);
		chk("wd_req_on", 32'(watchdog_irq_req), 1);
		rst_nmi_pin_n <= 1'b0;
		cyc(4);
		rst_nmi_pin_n <= 1'b1;
		cyc(4);
		chk("ext_rst", 32'(irq_flags), 32'h09);
		nmi_mode <= 1'b1;
		nmi_edge_falling <= 1'b1;
		@(posedge clk);
		rst_nmi_pin_n <= 1'b0;
		cyc(4);
		chk("nmi_flag", 32'(irq_flags), 32'h19);
		chk("nmi_req", 32'(nonmask_irq_req), 1);
		acc(1, 12'h008, 32'h09, 0, 0);
		nmi_edge_falling <= 1'b0;
		rst_nmi_pin_n <= 1'b1;
		cyc(4);
		chk("nmi_rise", 32'(irq_flags), 32'h19);
		power_up_clear <= 1'b1;
		@(posedge clk);
		power_up_clear <= 1'b0;
		@(posedge clk);
		chk("puc_en", 32'(irq_enables), 0);
		chk("puc_fl", 32'(irq_flags), 32'h0b);
		acc(1, 12'h008, 0, 0, 0);
		osc_fault <= 1'b1;
		cyc(4);
		chk("osc_fl", 32'(irq_flags), 32'h02);
		acc(1, 12'h000, 32'h02, 0, 0);
		chk("osc_req", 32'(nonmask_irq_req), 1);
		osc_fault <= 1'b0;
		acc(1, 12'h000, 32'h20, 0, 0);
		flash_violation <= 1'b1;
		cyc(2);
		chk("flash_req", 32'(nonmask_irq_req), 1);
		flash_violation <= 1'b0;
		acc(0, 12'h010, 0, 32'h1f, 0);
		acc(1, 12'h010, 32'h1f, 0, 0);
		acc(0, 12'h010, 0, 0, 0);
		acc(1, 12'h014, 32'h01, 0, 0);
		wd_pulse();
		chk("irq_set", 32'(irq), 1);
		acc(1, 12'h014, 0, 0, 0);
		chk("irq_mask", 32'(irq), 0);
		acc(1, 12'h014, 32'h01, 0, 0);
		chk("irq_unmask", 32'(irq), 1);
		acc(1, 12'h010, 32'h01, 0, 0);
		chk("irq_clr", 32'(irq), 0);
		// power-up clear in reset mode must drop the nonmask flag and set the osc flag
		acc(1, 12'h008, 32'h11, 0, 0);
		nmi_mode <= 1'b0;
		power_up_clear <= 1'b1;
		@(posedge clk);
		power_up_clear <= 1'b0;
		@(posedge clk);
		chk("puc_rst_mode", 32'(irq_flags), 32'h03);
		arst_n <= 1'b0;
		cyc(2);
		chk("por_fl", 32'(irq_flags), 32'h06);
		arst_n <= 1'b1;
		cyc(3);
		chk("rel_fl", 32'(irq_flags), 32'h06);
		tally_and_finish();
	end
endmodule : tb
bind sfr_bank sfr_bank_assertions #(.ADDR_W(ADDR_W)) sfr_bank_assertions_inst (.clk(clk),
	.arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .power_up_clear(power_up_clear), .watchdog_overflow(watchdog_overflow),
	.watchdog_interval_mode(watchdog_interval_mode), .flash_violation(flash_violation),
	.nmi_mode(nmi_mode), .osc_fault(osc_fault), .irq_enables(irq_enables),
	.irq_flags(irq_flags), .watchdog_irq_req(watchdog_irq_req),
	.nonmask_irq_req(nonmask_irq_req));
`default_nettype wire
